/* File: hdl/lts_defs.svh */
`ifndef LTS_DEFS_SVH
`define LTS_DEFS_SVH
// Clock and tick timing
`define LTS_CLK_HZ        20000000
`define LTS_TICK_S_DIV    1000
`define LTS_TICK_CYC      (`LTS_CLK_HZ / `LTS_TICK_S_DIV)
// Interval limits and defaults, in 1 ms ticks
`define LTS_TMR_W         27
`define LTS_TMR_MIN       27'h0000001
`define LTS_TMR_MAX       27'h5F5E0FF
`define LTS_TMR_RST       27'h0000001
`define LTS_TMR_DEF_TRIG  27'h0000064
`define LTS_TMR_DEF_ARM2  27'h00003E8
// Layer indices
`define LTS_L_ARM1        2'h0
`define LTS_L_ARM2        2'h1
`define LTS_L_TRIG        2'h2
// Link line defaults (1..6)
`define LTS_LINE_IN_RST   3'h1
`define LTS_LINE_OUT_RST  3'h2
`define LTS_LINE_MIN      3'h1
`define LTS_LINE_MAX      3'h6
`define LTS_NLINES        6
`define LTS_PULSE_CYC     16'h0001
`endif

/* File: hdl/lts_pkg.sv */
`default_nettype none
package lts_pkg;
  typedef enum logic [2:0] {
    LTS_SRC_PASS, LTS_SRC_STALL, LTS_SRC_KEY, LTS_SRC_BUS,
    LTS_SRC_LINK, LTS_SRC_EXT, LTS_SRC_TICK
  } lts_src_t;
  typedef struct packed {
    logic       valid;
    logic [1:0] layer;
    lts_src_t   src;
  } lts_src_cmd_t;
  typedef struct packed {
    logic       valid;
    logic [1:0] layer;
    logic [2:0] line;
  } lts_line_cmd_t;
  typedef struct packed {
    logic       valid;
    logic [1:0] layer;
    logic [26:0] ticks;
    logic        use_default;
  } lts_tmr_cmd_t;
  typedef struct packed {
    logic [15:0] arm1;
    logic [15:0] arm2;
    logic [15:0] trig;
  } lts_counts_t;
endpackage
`default_nettype wire

/* File: hdl/lts_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lts_defs.svh"
module lts_sequencer #(
  parameter int unsigned TICK_CYC = `LTS_TICK_CYC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  input  wire logic                  start_i,
  input  wire logic                  preset_i,
  input  wire lts_pkg::lts_src_cmd_t src_cmd_i,
  input  wire lts_pkg::lts_line_cmd_t in_line_cmd_i,
  input  wire lts_pkg::lts_tmr_cmd_t tmr_cmd_i,
  input  wire logic [2:0]            bypass_set_i,
  input  wire logic [2:0]            bypass_off_setting_i,
  input  wire logic                  protocol_set_i,
  input  wire logic                  shared_line_protocol_i,
  input  wire logic [2:0]            layer_imm_i,
  input  wire logic [2:0]            layer_skip_i,
  input  wire lts_pkg::lts_counts_t  counts_i,
  input  wire logic [8:0]            out_line_flat_i,
  input  wire logic [31:0]           wait_ticks_flat_i,
  input  wire logic                  bus_trig_i,
  input  wire logic                  key_i,
  input  wire logic                  ext_trig_i,
  input  wire logic [5:0]            link_line_i,
  input  wire logic                  action_done_i,
  output logic                       action_req_o,
  output logic [5:0]                 link_line_o,
  output logic [5:0]                 link_line_oe_o,
  output logic                       chan_done_o,
  output logic                       err_o,
  output logic [1:0]                 layer_o,
  output logic                       waiting_o,
  output logic                       shared_line_protocol_o,
  output logic [2:0]                 bypass_on_o
);
  import lts_pkg::*;

  typedef enum logic [2:0] {
    LTS_IDLE, LTS_EVT, LTS_WAIT, LTS_ACT, LTS_LEAVE
  } lts_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [5:0] link_s1_r, link_s2_r, link_s3_r;
  logic       ext_s1_r, ext_s2_r, ext_s3_r;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      link_s1_r <= 6'h00;
      link_s2_r <= 6'h00;
      link_s3_r <= 6'h00;
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      ext_s3_r  <= 1'b0;
    end else begin
      link_s1_r <= link_line_i;
      link_s2_r <= link_s1_r;
      link_s3_r <= link_s2_r;
      ext_s1_r  <= ext_trig_i;
      ext_s2_r  <= ext_s1_r;
      ext_s3_r  <= ext_s2_r;
    end
  end
  wire [5:0] link_rise = link_s2_r & ~link_s3_r;
  wire       ext_rise  = ext_s2_r & ~ext_s3_r;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration
  lts_src_t   src_r [3];
  logic [2:0] in_line_r [3];
  logic [2:0] byp_en_r;
  logic       shared_r;
  logic [`LTS_TMR_W-1:0] tmr_int_r [3];
  logic       cfg_err;
  wire  [1:0] sl = src_cmd_i.layer;
  wire  [1:0] il = in_line_cmd_i.layer;
  wire  [1:0] tl = tmr_cmd_i.layer;
  wire  [2:0] il_out = out_line_flat_i[il*3 +: 3];

  always_comb begin
    cfg_err = 1'b0;
    if (src_cmd_i.valid && (sl == `LTS_L_ARM1 || sl > `LTS_L_TRIG) && src_cmd_i.src == LTS_SRC_TICK)
      cfg_err = 1'b1;
    if (in_line_cmd_i.valid && (in_line_cmd_i.line == il_out ||
        in_line_cmd_i.line < `LTS_LINE_MIN || in_line_cmd_i.line > `LTS_LINE_MAX))
      cfg_err = 1'b1;
    if (tmr_cmd_i.valid && !tmr_cmd_i.use_default && (tl == `LTS_L_ARM1 ||
        tmr_cmd_i.ticks < `LTS_TMR_MIN || tmr_cmd_i.ticks > `LTS_TMR_MAX))
      cfg_err = 1'b1;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 3; i++) begin
        src_r[i]     <= LTS_SRC_PASS;
        in_line_r[i] <= `LTS_LINE_IN_RST;
        tmr_int_r[i] <= `LTS_TMR_RST;
      end
      byp_en_r <= 3'b000;
      shared_r <= 1'b0;
    end else if (preset_i) begin
      src_r[0] <= LTS_SRC_PASS;
      src_r[1] <= LTS_SRC_PASS;
      src_r[2] <= LTS_SRC_KEY;
      for (int i = 0; i < 3; i++) begin
        in_line_r[i] <= `LTS_LINE_IN_RST;
        tmr_int_r[i] <= `LTS_TMR_RST;
      end
      byp_en_r <= 3'b100;
      shared_r <= 1'b0;
    end else if (!cfg_err) begin
      if (src_cmd_i.valid && sl <= `LTS_L_TRIG)
        src_r[sl] <= src_cmd_i.src;
      if (in_line_cmd_i.valid && il <= `LTS_L_TRIG)
        in_line_r[il] <= in_line_cmd_i.line;
      if (tmr_cmd_i.valid && tmr_cmd_i.use_default) begin
        tmr_int_r[`LTS_L_TRIG] <= `LTS_TMR_DEF_TRIG;
        tmr_int_r[`LTS_L_ARM2] <= `LTS_TMR_DEF_ARM2;
      end else if (tmr_cmd_i.valid && tl <= `LTS_L_TRIG)
        tmr_int_r[tl] <= tmr_cmd_i.ticks;
      byp_en_r <= (byp_en_r | bypass_set_i) & ~bypass_off_setting_i;
      if (protocol_set_i)
        shared_r <= shared_line_protocol_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 1 ms tick
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interval timers, free of the wait time
  logic [`LTS_TMR_W-1:0] itmr_r [3];
  logic [2:0]            tev_r;
  logic [2:0]            tmr_on;
  lts_state_t            state_r;
  logic [1:0]            lay_r;
  always_comb begin
    for (int i = 0; i < 3; i++)
      tmr_on[i] = (i != 0) && (src_r[i] == LTS_SRC_TICK) && (state_r != LTS_IDLE);
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 3; i++)
        itmr_r[i] <= '0;
      tev_r <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // Consumed event clears; a new expiry below wins
        if (state_r == LTS_EVT && lay_r == 2'(i) && tev_r[i])
          tev_r[i] <= 1'b0;
        if (!tmr_on[i]) begin
          itmr_r[i] <= '0;
          tev_r[i]  <= 1'b0;
        end else if (itmr_r[i] == '0) begin
          itmr_r[i] <= tmr_int_r[i];
          tev_r[i]  <= 1'b1;
        end else if (tick_r) begin
          if (itmr_r[i] == `LTS_TMR_MIN) begin
            itmr_r[i] <= tmr_int_r[i];
            tev_r[i]  <= 1'b1;
          end else
            itmr_r[i] <= itmr_r[i] - `LTS_TMR_MIN;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic [15:0] loop_r [3];
  logic [2:0]  first_r;
  logic [31:0] wcnt_r;
  logic        skip_wait_r;
  logic        evt;
  lts_src_t    cur_src;
  wire  [15:0] cnt [3] = '{counts_i.arm1, counts_i.arm2, counts_i.trig};
  wire  [2:0]  cur_line = in_line_r[lay_r] - 3'h1;
  assign cur_src = src_r[lay_r];
  always_comb begin
    case (cur_src)
      LTS_SRC_PASS:  evt = 1'b1;
      LTS_SRC_KEY:   evt = key_i;
      LTS_SRC_BUS:   evt = bus_trig_i;
      LTS_SRC_LINK:  evt = link_rise[cur_line];
      LTS_SRC_EXT:   evt = ext_rise;
      LTS_SRC_TICK:  evt = tev_r[lay_r];
      default:       evt = 1'b0;
    endcase
  end
  wire        byp_now  = byp_en_r[lay_r] && first_r[lay_r] &&
                         (cur_src == LTS_SRC_EXT || cur_src == LTS_SRC_LINK);
  wire        waiting  = (state_r == LTS_EVT);
  wire [31:0] wt       = (lay_r == `LTS_L_ARM1) ? 32'h0 :
                         {16'h0, wait_ticks_flat_i[(lay_r-2'h1)*16 +: 16]};
  logic       pulse_req;
  logic       pulse_link;
  logic [1:0] pulse_lay;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r      <= LTS_IDLE;
      lay_r        <= `LTS_L_ARM1;
      first_r      <= 3'b111;
      wcnt_r       <= 32'h0;
      skip_wait_r  <= 1'b0;
      err_o        <= 1'b0;
      action_req_o <= 1'b0;
      pulse_req    <= 1'b0;
      pulse_link   <= 1'b0;
      pulse_lay    <= 2'h0;
      for (int i = 0; i < 3; i++)
        loop_r[i] <= 16'h0;
    end else begin
      err_o     <= 1'b0;
      pulse_req <= 1'b0;
      if (|layer_skip_i && !(waiting && layer_skip_i[lay_r]))
        err_o <= 1'b1;
      if (|layer_imm_i && !(waiting && layer_imm_i[lay_r]))
        err_o <= 1'b1;
      if (cfg_err)
        err_o <= 1'b1;
      case (state_r)
        LTS_IDLE: begin
          first_r <= 3'b111;
          if (start_i) begin
            state_r   <= LTS_EVT;
            lay_r     <= `LTS_L_ARM1;
            loop_r[0] <= 16'h0;
          end
        end
        LTS_EVT: begin
          if (byp_now || layer_imm_i[lay_r]) begin
            state_r <= LTS_ACT;
          end else if (layer_skip_i[lay_r] || (cur_src != LTS_SRC_STALL && evt)) begin
            state_r <= LTS_WAIT;
            wcnt_r  <= 32'h0;
          end
        end
        LTS_WAIT: begin
          if (wcnt_r >= wt)
            state_r <= LTS_ACT;
          else if (tick_r)
            wcnt_r <= wcnt_r + 32'h1;
        end
        LTS_ACT: begin
          first_r[lay_r] <= 1'b0;
          if (lay_r != `LTS_L_TRIG) begin
            if (byp_en_r[lay_r]) begin
              pulse_req  <= 1'b1;
              pulse_link <= (cur_src == LTS_SRC_LINK);
              pulse_lay  <= lay_r;
            end
            lay_r   <= lay_r + 2'h1;
            loop_r[lay_r + 2'h1] <= 16'h0;
            first_r[lay_r + 2'h1] <= 1'b1;
            state_r <= LTS_EVT;
          end else if (!action_req_o) begin
            action_req_o <= 1'b1;
          end else if (action_done_i) begin
            action_req_o <= 1'b0;
            pulse_req  <= 1'b1;
            pulse_link <= 1'b1;
            pulse_lay  <= `LTS_L_TRIG;
            state_r    <= LTS_LEAVE;
          end
        end
        LTS_LEAVE: begin
          if (cnt[lay_r] == 16'h0 || loop_r[lay_r] + 16'h1 < cnt[lay_r]) begin
            loop_r[lay_r] <= loop_r[lay_r] + 16'h1;
            state_r <= LTS_EVT;
          end else begin
            if (lay_r == `LTS_L_ARM1)
              state_r <= LTS_IDLE;
            else
              lay_r <= lay_r - 2'h1;
          end
        end
        default: state_r <= LTS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pulses and status
  wire [2:0] pl_out = out_line_flat_i[pulse_lay*3 +: 3] - 3'h1;
  wire [2:0] pl_in  = in_line_r[`LTS_L_TRIG] - 3'h1;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      link_line_o    <= 6'h00;
      link_line_oe_o <= 6'h00;
      chan_done_o    <= 1'b0;
      layer_o        <= 2'h0;
      waiting_o      <= 1'b0;
      shared_line_protocol_o <= 1'b0;
      bypass_on_o    <= 3'b000;
    end else begin
      link_line_o    <= 6'h00;
      link_line_oe_o <= 6'h00;
      chan_done_o    <= 1'b0;
      if (pulse_req) begin
        if (!pulse_link)
          chan_done_o <= 1'b1;
        // Shared line only in trigger layer
        else if (pulse_lay == `LTS_L_TRIG && shared_r) begin
          link_line_o[pl_in]    <= 1'b1;
          link_line_oe_o[pl_in] <= 1'b1;
        end else begin
          link_line_o[pl_out]    <= 1'b1;
          link_line_oe_o[pl_out] <= 1'b1;
        end
      end
      layer_o     <= lay_r;
      waiting_o   <= waiting;
      shared_line_protocol_o <= shared_r;
      bypass_on_o <= byp_en_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  stall_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (waiting && src_r[lay_r] == LTS_SRC_STALL && !layer_imm_i[lay_r] && !layer_skip_i[lay_r]
     && !byp_now) |=> (state_r == LTS_EVT))
    else $error("stall layer left without command");
  skip_err_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (layer_skip_i != 3'b000 && !waiting) |=> err_o)
    else $error("skip outside wait not flagged");
  tick_src_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (src_r[0] != LTS_SRC_TICK))
    else $error("first arm layer holds interval source");
  line_clash_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (in_line_cmd_i.valid && in_line_cmd_i.line == il_out && il <= `LTS_L_TRIG && !preset_i)
    |=> ($stable(in_line_r[0]) && $stable(in_line_r[1]) && $stable(in_line_r[2]) && err_o))
    else $error("clashing input line accepted");
  pass_move_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (waiting && cur_src == LTS_SRC_PASS && !byp_now && !layer_imm_i[lay_r])
    |=> (state_r == LTS_WAIT))
    else $error("pass-through did not move on");
  timer_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (src_r[2] != LTS_SRC_TICK) |=> (tev_r[2] == 1'b0))
    else $error("timer event with other source");
  arm_pulse_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (pulse_req && pulse_lay != `LTS_L_TRIG) |-> $past(byp_en_r[lay_r]))
    else $error("arm pulse without bypass");
  route_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (pulse_req && !pulse_link) |=> (chan_done_o && link_line_oe_o == 6'h00))
    else $error("pulse misrouted");
  wait_skip_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (waiting && layer_skip_i[lay_r] && !byp_now && !layer_imm_i[lay_r])
    |=> (state_r == LTS_WAIT))
    else $error("skip did not enter wait");
endmodule
`default_nettype wire

/* File: testbench/lts_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module lts_link_partner (
  input  wire logic       mclk_i,
  input  wire logic [5:0] fire_i,
  input  wire logic [3:0] delay_i,
  input  wire logic [5:0] dev_line_i,
  input  wire logic [5:0] dev_oe_i,
  output logic [5:0]      line_o
);
  logic [5:0] drive_r = 6'h00;
  logic [5:0] pend_r;
  ////////////////////////////////////////////////////////////////
  // lines idle low, device drive joins ours
  assign line_o = drive_r | (dev_line_i & dev_oe_i);
  // Pulse held three cycles, after a prompt or slow start
  always @(posedge mclk_i) begin
    if (|fire_i) begin
      pend_r = fire_i;
      repeat (delay_i + 1) @(negedge mclk_i);
      drive_r = pend_r;
      repeat (3) @(negedge mclk_i);
      drive_r = 6'h00;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_layered_trigger_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lts_defs.svh"
module tb_layered_trigger_sequencer;
  import lts_pkg::*;
  localparam int TC = 4;
  localparam int P_BYP = 0, P_IMM = 1, P_SKIP = 2, P_GO = 3, P_BUS = 4;
  localparam int P_KEY = 5, P_PRE = 6, P_PROT = 7, P_EXT = 8, P_OFF = 9;
  logic          mclk_i, reset_i, start_i, preset_i, protocol_set_i, shared_i;
  logic          bus_trig_i, key_i, ext_trig_i, action_done_i;
  lts_src_cmd_t  src_cmd_i;
  lts_line_cmd_t line_cmd_i;
  lts_tmr_cmd_t  tmr_cmd_i;
  lts_counts_t   counts_i;
  logic [2:0]    byp_set_i, byp_off_i, imm_i, skip_i, bypass_on_o, r;
  logic [8:0]    out_lines_i;
  logic [31:0]   wait_i;
  logic [5:0]    link_in, link_line_o, link_line_oe_o, fire, lk_last;
  logic [3:0]    fire_dly;
  logic          action_req_o, chan_done_o, err_o, waiting_o, shared_o;
  logic [1:0]    layer_o;
  int            fail_count, cmp_count, cd_cnt, err_cnt, lk_cnt, n, m, k;

  lts_sequencer #(.TICK_CYC(TC)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .start_i(start_i), .preset_i(preset_i),
    .src_cmd_i(src_cmd_i), .in_line_cmd_i(line_cmd_i), .tmr_cmd_i(tmr_cmd_i),
    .bypass_set_i(byp_set_i), .bypass_off_setting_i(byp_off_i),
    .protocol_set_i(protocol_set_i), .shared_line_protocol_i(shared_i),
    .layer_imm_i(imm_i), .layer_skip_i(skip_i), .counts_i(counts_i),
    .out_line_flat_i(out_lines_i), .wait_ticks_flat_i(wait_i),
    .bus_trig_i(bus_trig_i), .key_i(key_i), .ext_trig_i(ext_trig_i),
    .link_line_i(link_in), .action_done_i(action_done_i),
    .action_req_o(action_req_o), .link_line_o(link_line_o),
    .link_line_oe_o(link_line_oe_o), .chan_done_o(chan_done_o), .err_o(err_o),
    .layer_o(layer_o), .waiting_o(waiting_o), .shared_line_protocol_o(shared_o),
    .bypass_on_o(bypass_on_o));
  lts_link_partner peer (.mclk_i(mclk_i), .fire_i(fire), .delay_i(fire_dly),
    .dev_line_i(link_line_o), .dev_oe_i(link_line_oe_o), .line_o(link_in));

  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////
  // Output pulse counters and channel switch responder
  always @(posedge mclk_i) begin
    if (chan_done_o === 1'h1) cd_cnt++;
    if (err_o === 1'h1) err_cnt++;
    if (|(link_line_o & link_line_oe_o) === 1'h1) begin
      lk_cnt++;
      lk_last = link_line_o;
    end
  end
  always @(negedge mclk_i) action_done_i <= action_req_o;
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge mclk_i);
  endtask
  function automatic void drv(input int w, input logic [2:0] v);
    case (w)
      P_BYP: byp_set_i = v;
      P_IMM: imm_i = v;
      P_SKIP: skip_i = v;
      P_GO: start_i = v[0];
      P_BUS: bus_trig_i = v[0];
      P_KEY: key_i = v[0];
      P_PRE: preset_i = v[0];
      P_PROT: protocol_set_i = v[0];
      P_OFF: byp_off_i = v;
      default: ext_trig_i = v[0];
    endcase
  endfunction
  task automatic pulse(input int w, input logic [2:0] v);
    tick(1);
    drv(w, v);
    tick(1);
    drv(w, 3'h0);
  endtask
  task automatic src(input logic [1:0] l, input lts_src_t s);
    tick(1);
    src_cmd_i = {1'h1, l, s};
    tick(1);
    src_cmd_i = '0;
  endtask
  task automatic lin(input logic [1:0] l, input logic [2:0] ln);
    tick(1);
    line_cmd_i = {1'h1, l, ln};
    tick(1);
    line_cmd_i = '0;
  endtask
  task automatic tmr(input logic [26:0] t, input logic d);
    tick(1);
    tmr_cmd_i = {1'h1, 2'h2, t, d};
    tick(1);
    tmr_cmd_i = '0;
  endtask
  task automatic wait_req(input int lim, output int c);
    c = 0;
    while (action_req_o !== 1'h1 && c < lim) begin
      tick(1);
      c++;
    end
  endtask
  task automatic rst(input int c);
    reset_i = 1'h1;
    {start_i, preset_i, protocol_set_i, shared_i, bus_trig_i, key_i, ext_trig_i} = 7'h00;
    {byp_set_i, byp_off_i, imm_i, skip_i, fire, fire_dly} = 22'h000000;
    src_cmd_i = '0;
    line_cmd_i = '0;
    tmr_cmd_i = '0;
    counts_i = {16'h0001, 16'h0001, 16'h0001};
    out_lines_i = 9'h092;
    wait_i = 32'h00000000;
    tick(c);
    reset_i = 1'h0;
    tick(1);
  endtask
  function automatic logic exp_src_err(input int l, input int s);
    return (l == `LTS_L_ARM1) && (s == LTS_SRC_TICK);
  endfunction
  function automatic logic [5:0] line_mask(input logic [2:0] ln);
    return 6'h01 << (ln - 3'h1);
  endfunction
  function automatic int period(input logic d);
    return d ? `LTS_TMR_DEF_TRIG * TC : 10 * TC;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    n = $urandom(32'h5126);
    rst(12);
    check("rst_bypass", bypass_on_o, 3'h0);
    check("rst_shared", shared_o, 1'h0);
    pulse(P_PRE, 3'h1);
    tick(2);
    check("pre_bypass", bypass_on_o, 3'h4);
    pulse(P_GO, 3'h1);
    tick(10);
    check("pre_pass", {waiting_o, layer_o}, {1'h1, `LTS_L_TRIG});
    pulse(P_KEY, 3'h1);
    wait_req(10, n);
    check("key_req", action_req_o, 1'h1);
    shared_i = 1'h1;
    pulse(P_PROT, 3'h1);
    tick(2);
    check("shared_set", shared_o, 1'h1);
    k = lk_cnt;
    pulse(P_GO, 3'h1);
    tick(10);
    pulse(P_KEY, 3'h1);
    tick(15);
    check("shared_line", lk_last, line_mask(`LTS_LINE_IN_RST));
    check("shared_cnt", lk_cnt - k, 1);
    rst(2);
    for (int l = 0; l < 3; l++) for (int s = 0; s < 7; s++) begin
      n = err_cnt;
      src(l[1:0], lts_src_t'(s));
      tick(2);
      check("src_err", err_cnt - n, exp_src_err(l, s));
    end
    for (int b = 0; b < 6; b++) begin
      n = err_cnt;
      pulse(b < 3 ? P_SKIP : P_IMM, 3'h1 << (b % 3));
      tick(2);
      check("idle_err", err_cnt - n, 1);
    end
    for (int i = 0; i < 6; i++) begin
      k = $urandom % 5;
      r = (i < 3) ? 3'h2 : ((k == 0) ? 3'h1 : 3'(k + 2));
      n = err_cnt;
      lin(2'(i % 3), r);
      tick(2);
      check("line_err", err_cnt - n, r == 3'h2);
    end
    rst(2);
    counts_i = {16'h0001, 16'h0001, 16'h0002};
    src(2'h2, LTS_SRC_STALL);
    m = cd_cnt + lk_cnt;
    pulse(P_GO, 3'h1);
    tick(30);
    check("stall", {waiting_o, layer_o, action_req_o}, {1'h1, 2'h2, 1'h0});
    pulse(P_SKIP, 3'h4);
    wait_req(10, n);
    check("skip_go", n < 10, 1);
    tick(25);
    check("restall", {waiting_o, layer_o, action_req_o}, {1'h1, 2'h2, 1'h0});
    pulse(P_IMM, 3'h4);
    wait_req(10, n);
    check("imm_go", n < 10, 1);
    tick(15);
    check("trig_pulses", cd_cnt + lk_cnt - m, 2);
    for (int w = 0; w < 2; w++) begin
      rst(2);
      wait_i = 32'h00050000;
      src(2'h2, LTS_SRC_STALL);
      pulse(P_GO, 3'h1);
      tick(10);
      pulse(w ? P_IMM : P_SKIP, 3'h4);
      wait_req(40, n);
      check("wait_len", w ? n < 2 * TC : (n >= 4 * TC && n <= 5 * TC + 8), 1);
    end
    for (int d = 0; d < 2; d++) begin
      rst(2);
      counts_i = {16'h0001, 16'h0001, 16'h0002};
      tmr(27'h000000A, d[0]);
      src(2'h2, LTS_SRC_TICK);
      pulse(P_GO, 3'h1);
      wait_req(20, n);
      check("tick_first", n < 20, 1);
      tick(3);
      wait_req(500, n);
      n = n + 3;
      check("tick_gap", n >= period(d[0]) - 8 && n <= period(d[0]) + 8, 1);
    end
    for (int b = 0; b < 3; b++) begin
      rst(2);
      src(2'h2, LTS_SRC_STALL);
      src(2'h0, b == 1 ? LTS_SRC_LINK : LTS_SRC_EXT);
      pulse(P_BYP, 3'h1);
      if (b == 2) pulse(P_OFF, 3'h1);
      tick(2);
      check("byp_state", bypass_on_o, b < 2 ? 3'h1 : 3'h0);
      m = cd_cnt;
      k = lk_cnt;
      pulse(P_GO, 3'h1);
      tick(15);
      check("byp_pass", layer_o, b < 2 ? 2'h2 : 2'h0);
      check("byp_cd", cd_cnt - m, b == 0);
      check("byp_lk", lk_cnt - k, b == 1);
      if (b == 1) check("byp_line", lk_last, line_mask(3'h2));
    end
    pulse(P_EXT, 3'h1);
    tick(15);
    check("ext_go", layer_o, 2'h2);
    check("no_arm_pulse", cd_cnt + lk_cnt - m - k, 0);
    for (int s = 0; s < 3; s++) begin
      rst(2);
      k = $urandom % 5;
      r = (k == 0) ? 3'h1 : 3'(k + 2);
      lin(2'h2, r);
      src(2'h2, s == 0 ? LTS_SRC_BUS : (s == 1 ? LTS_SRC_EXT : LTS_SRC_LINK));
      pulse(P_GO, 3'h1);
      tick(10);
      if (s == 2) begin
        pulse(P_PROT, 3'h1);
        tick(1);
        fire = line_mask(3'(r % 6 + 1));
        tick(1);
        fire = 6'h00;
        tick(15);
        check("wrong_line", action_req_o, 1'h0);
        tick(1);
        fire = line_mask(r);
        fire_dly = 4'($urandom % 8);
        tick(1);
        fire = 6'h00;
      end
      else pulse(s == 0 ? P_BUS : P_EXT, 3'h1);
      wait_req(30, n);
      check("event_go", action_req_o, 1'h1);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
